// ---- pkg/rxb_defines.svh ----
`ifndef RXB_DEFINES_SVH
`define RXB_DEFINES_SVH

// Channel slots inside the per-channel arrays
`define RXB_CH_RSP 0
`define RXB_CH_PST 1
`define RXB_CH_NP 2
`define RXB_NUM_CH 3

// Empty-byte codes and the bit that marks an invalid upper half
`define RXB_MTY_FULL 3'h0
`define RXB_MTY_HALF 3'h4
`define RXB_MTY_HALF_BIT 2

// Window code for packets that carry no address
`define RXB_WIN_NONE 3'h7

// Stored word layout: {start, end, empty code, data}
`define RXB_DAT_MSB 63
`define RXB_MTY_LSB 64
`define RXB_MTY_MSB 66
`define RXB_EOP_BIT 67
`define RXB_SOP_BIT 68
`define RXB_WORD_W 69

// Default sizes
`define RXB_WORD_AW 6
`define RXB_PKT_AW 3
`define RXB_LEN_W 4
`define RXB_TAG_W 8

`endif

// ---- pkg/rxb_pkg.sv ----
`include "rxb_defines.svh"

package rxb_pkg;

  // Empty-byte code seen by the reader
  typedef enum logic [2:0] {
    RXB_MTY_ALL_VALID = `RXB_MTY_FULL,
    RXB_MTY_UPPER_EMPTY = `RXB_MTY_HALF
  } rxb_mty_t;

  // Matched address window code
  typedef logic [2:0] rxb_win_t;

  // One received word as it sits in a buffer
  typedef logic [`RXB_WORD_W-1:0] rxb_word_t;

endpackage : rxb_pkg

// ---- design/rxb_mem.sv ----
`timescale 1ns/1ps
`include "rxb_defines.svh"

// Simple dual-port word store with a registered read port
module rxb_mem #(
  parameter int W = `RXB_WORD_W,
  parameter int AW = `RXB_WORD_AW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem_q [2**AW];

  // Array left without reset so it maps onto block memory
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read data holds whenever no read is issued
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : rxb_mem

// ---- design/rxb_sync.sv ----
`timescale 1ns/1ps

// Two-flop synchroniser for asynchronous level inputs
module rxb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : rxb_sync

// ---- design/rxb_top.sv ----
// Contract
// - Three read ports: response, posted, non-posted
// - Little-endian bytes, first byte lowest lane
// - Packet is command word then data words
// - Dataless command: start and end together
// - Empty code only 000 or 100
// - Non-zero empty code only on last word
// - Dataless 32-bit command: code 100, start, end
// - Valid and data change only on pull; a flush clears valid without a pull
// - Pull sampled, outputs driven next edge
// - Packets stream back to back under pull
// - Waiting high when readable packet exists
// - Window code 0-5, 6 unused, 7 none
// - Window code valid with start; not response
// - Circular buffers keep arrival order per channel
// - PassPW-clear waits for earlier posted reads
// - PassPW-set readable once at queue head
// - PassPW-set behind PassPW-clear waits too
// - Posted never passes posted, may pass others
// - Link reset and power-good are inputs only
`timescale 1ns/1ps
`include "rxb_defines.svh"

module rxb_top #(
  parameter int WORD_AW = `RXB_WORD_AW,
  parameter int PKT_AW = `RXB_PKT_AW,
  parameter int LEN_W = `RXB_LEN_W,
  parameter int TAG_W = `RXB_TAG_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic link_reset_n_in,
  input wire logic link_power_good_in,
  input wire logic fill_response_valid,
  input wire logic [63:0] fill_response_data,
  input wire logic fill_response_end,
  input wire logic [2:0] fill_response_empty_code,
  input wire logic fill_response_passpw,
  output logic fill_response_ready,
  input wire logic fill_posted_valid,
  input wire logic [63:0] fill_posted_data,
  input wire logic fill_posted_end,
  input wire logic [2:0] fill_posted_empty_code,
  input wire logic fill_posted_passpw,
  input wire logic [2:0] fill_posted_window,
  output logic fill_posted_ready,
  input wire logic fill_nonposted_valid,
  input wire logic [63:0] fill_nonposted_data,
  input wire logic fill_nonposted_end,
  input wire logic [2:0] fill_nonposted_empty_code,
  input wire logic fill_nonposted_passpw,
  input wire logic [2:0] fill_nonposted_window,
  output logic fill_nonposted_ready,
  input wire logic rx_response_pull_enable,
  output logic [63:0] rx_response_data,
  output rxb_pkg::rxb_mty_t rx_response_empty_code,
  output logic rx_response_start,
  output logic rx_response_end,
  output logic rx_response_word_valid,
  output logic rx_response_packet_waiting,
  input wire logic rx_posted_pull_enable,
  output logic [63:0] rx_posted_data,
  output rxb_pkg::rxb_mty_t rx_posted_empty_code,
  output logic rx_posted_start,
  output logic rx_posted_end,
  output logic rx_posted_word_valid,
  output logic rx_posted_packet_waiting,
  output rxb_pkg::rxb_win_t rx_posted_window_match_code,
  input wire logic rx_nonposted_pull_enable,
  output logic [63:0] rx_nonposted_data,
  output rxb_pkg::rxb_mty_t rx_nonposted_empty_code,
  output logic rx_nonposted_start,
  output logic rx_nonposted_end,
  output logic rx_nonposted_word_valid,
  output logic rx_nonposted_packet_waiting,
  output rxb_pkg::rxb_win_t rx_nonposted_window_match_code
);
  import rxb_pkg::*;

  localparam int NCH = `RXB_NUM_CH;
  localparam int PD = 2**PKT_AW;
  localparam logic [WORD_AW:0] USED_LIMIT = (WORD_AW+1)'(2**WORD_AW - 2);
  localparam logic [PKT_AW:0] DESC_LIMIT = (PKT_AW+1)'(PD - 2);
  localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

  // Link reset and power-good are only ever sampled, never driven
  logic [1:0] link_raw_w;
  logic [1:0] link_sync_w;
  logic flush;

  assign link_raw_w = {link_power_good_in, link_reset_n_in};

  rxb_sync #(
    .W(2)
  ) u_link_sync (
    .clk(clk),
    .rstn(rstn),
    .d(link_raw_w),
    .q(link_sync_w)
  );

  // A link reset or power loss destroys all buffered packets
  assign flush = ~link_sync_w[0] | ~link_sync_w[1];

  // Fill-side inputs gathered per channel
  logic [NCH-1:0] fill_valid_w;
  logic [NCH-1:0] fill_end_w;
  logic [NCH-1:0] fill_pass_w;
  logic [NCH-1:0] pull_w;
  logic [63:0] fill_data_w [NCH];
  logic [2:0] fill_mty_w [NCH];
  logic [2:0] fill_win_w [NCH];

  assign fill_valid_w = {fill_nonposted_valid, fill_posted_valid, fill_response_valid};
  assign fill_end_w = {fill_nonposted_end, fill_posted_end, fill_response_end};
  assign fill_pass_w = {fill_nonposted_passpw, fill_posted_passpw, fill_response_passpw};
  assign pull_w = {rx_nonposted_pull_enable, rx_posted_pull_enable, rx_response_pull_enable};
  assign fill_data_w[`RXB_CH_RSP] = fill_response_data;
  assign fill_data_w[`RXB_CH_PST] = fill_posted_data;
  assign fill_data_w[`RXB_CH_NP] = fill_nonposted_data;
  assign fill_mty_w[`RXB_CH_RSP] = fill_response_empty_code;
  assign fill_mty_w[`RXB_CH_PST] = fill_posted_empty_code;
  assign fill_mty_w[`RXB_CH_NP] = fill_nonposted_empty_code;
  // Responses are never claimed by address
  assign fill_win_w[`RXB_CH_RSP] = `RXB_WIN_NONE;
  assign fill_win_w[`RXB_CH_PST] = fill_posted_window;
  assign fill_win_w[`RXB_CH_NP] = fill_nonposted_window;

  // Per-channel results back to the port level
  logic [NCH-1:0] first_push_w;
  logic [NCH-1:0] last_pop_w;
  logic [NCH-1:0] valid_w;
  logic [NCH-1:0] dav_w;
  logic [NCH-1:0] ready_w;
  rxb_word_t rd_word_w [NCH];
  rxb_win_t win_w [NCH];

  // Posted arrival and completion counters order the other channels
  logic [TAG_W-1:0] posted_wr_q;
  logic [TAG_W-1:0] posted_rd_q;

  always_ff @(posedge clk) begin
    if (!rstn || flush) begin
      posted_wr_q <= '0;
      posted_rd_q <= '0;
    end else begin
      if (first_push_w[`RXB_CH_PST]) posted_wr_q <= posted_wr_q + 1'b1;
      if (last_pop_w[`RXB_CH_PST]) posted_rd_q <= posted_rd_q + 1'b1;
    end
  end

  // One identical buffer per virtual channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [WORD_AW-1:0] wr_ptr_q;
    logic [WORD_AW-1:0] rd_ptr_q;
    logic [WORD_AW:0] used_q;
    logic [WORD_AW:0] used_d;
    logic [PKT_AW-1:0] dwp_q;
    logic [PKT_AW-1:0] drp_q;
    logic [PKT_AW:0] pkt_cnt_q;
    logic [PKT_AW:0] pkt_cnt_d;
    logic [PKT_AW:0] dcnt_q;
    logic [PKT_AW:0] dcnt_d;
    logic first_q;
    logic [LEN_W-1:0] len_q;
    logic [LEN_W-1:0] rem_q;
    logic valid_q;
    logic dav_q;
    logic ready_q;
    rxb_win_t win_q;
    logic [LEN_W-1:0] d_len_q [PD];
    logic d_pass_q [PD];
    logic [TAG_W-1:0] d_tag_q [PD];
    rxb_win_t d_win_q [PD];
    logic push;
    logic first_push;
    logic end_push;
    logic [TAG_W-1:0] lag;
    logic head_rel;
    logic head_ok;
    logic busy;
    logic start;
    logic pop;
    logic last_pop;
    logic [2:0] mty_clean;
    rxb_word_t wr_word;

    // Fill side: accepted word, start flag derived from packet framing
    assign push = fill_valid_w[i] & ready_q & ~flush;
    assign first_push = push & first_q;
    assign end_push = push & fill_end_w[i];
    // Only a last word may carry an upper-half-empty code
    assign mty_clean = (fill_end_w[i] && fill_mty_w[i][`RXB_MTY_HALF_BIT]) ?
                       `RXB_MTY_HALF : `RXB_MTY_FULL;
    assign wr_word = {first_q, fill_end_w[i], mty_clean, fill_data_w[i]};

    // Release test: signed lag so the tag counters may wrap
    assign lag = posted_rd_q - d_tag_q[drp_q];
    assign head_rel = (i == `RXB_CH_PST) | d_pass_q[drp_q] | ~lag[TAG_W-1];
    assign head_ok = (pkt_cnt_q != '0) & head_rel;
    assign busy = rem_q != '0;
    // A packet only starts once complete, so its words never stall
    assign start = pull_w[i] & ~busy & head_ok & ~flush;
    assign pop = start | (pull_w[i] & busy & ~flush);
    assign last_pop = (start & (d_len_q[drp_q] == LEN_ONE)) | (pop & busy & (rem_q == LEN_ONE));

    assign used_d = used_q + {{WORD_AW{1'b0}}, push} - {{WORD_AW{1'b0}}, pop};
    assign pkt_cnt_d = pkt_cnt_q + {{PKT_AW{1'b0}}, end_push} - {{PKT_AW{1'b0}}, start};
    assign dcnt_d = dcnt_q + {{PKT_AW{1'b0}}, first_push} - {{PKT_AW{1'b0}}, start};

    // Circular word pointers keep arrival order
    always_ff @(posedge clk) begin
      if (!rstn || flush) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        used_q <= '0;
      end else begin
        if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
        if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
        used_q <= used_d;
      end
    end

    // Packet framing on the fill side
    always_ff @(posedge clk) begin
      if (!rstn || flush) begin
        first_q <= 1'b1;
        len_q <= '0;
        dwp_q <= '0;
      end else if (push) begin
        first_q <= fill_end_w[i];
        len_q <= fill_end_w[i] ? '0 : len_q + 1'b1;
        if (fill_end_w[i]) dwp_q <= dwp_q + 1'b1;
      end
    end

    // Descriptor store; no reset needed as counts guard every read
    always_ff @(posedge clk) begin
      if (first_push) begin
        d_pass_q[dwp_q] <= fill_pass_w[i];
        d_tag_q[dwp_q] <= posted_wr_q;
        d_win_q[dwp_q] <= fill_win_w[i];
      end
      if (end_push) d_len_q[dwp_q] <= len_q + 1'b1;
    end

    // Read side: descriptor head, words left and counts
    always_ff @(posedge clk) begin
      if (!rstn || flush) begin
        drp_q <= '0;
        rem_q <= '0;
        pkt_cnt_q <= '0;
        dcnt_q <= '0;
      end else begin
        if (start) drp_q <= drp_q + 1'b1;
        if (start) rem_q <= d_len_q[drp_q] - 1'b1;
        else if (pop) rem_q <= rem_q - 1'b1;
        pkt_cnt_q <= pkt_cnt_d;
        dcnt_q <= dcnt_d;
      end
    end

    // Valid changes only when the pull is sampled or on a flush; empty pull gives valid low
    always_ff @(posedge clk) begin
      if (!rstn || flush) begin
        valid_q <= 1'b0;
      end else if (pull_w[i]) begin
        valid_q <= pop;
      end
    end

    // Window code tracks the command word it belongs to
    always_ff @(posedge clk) begin
      if (!rstn) begin
        win_q <= `RXB_WIN_NONE;
      end else if (start) begin
        win_q <= d_win_q[drp_q];
      end
    end

    // Waiting lags by a cycle; a stale high only costs an empty pull
    always_ff @(posedge clk) begin
      if (!rstn || flush) begin
        dav_q <= 1'b0;
        ready_q <= 1'b0;
      end else begin
        dav_q <= head_ok & ~(start & (pkt_cnt_q == {{PKT_AW{1'b0}}, 1'b1}));
        ready_q <= (used_d <= USED_LIMIT) & (dcnt_d <= DESC_LIMIT);
      end
    end

    // Registered read keeps data still between pulls
    rxb_mem #(
      .W(`RXB_WORD_W),
      .AW(WORD_AW)
    ) u_mem (
      .clk(clk),
      .rstn(rstn),
      .wr_en(push),
      .wr_addr(wr_ptr_q),
      .wr_data(wr_word),
      .rd_en(pop),
      .rd_addr(rd_ptr_q),
      .rd_data(rd_word_w[i])
    );

    assign first_push_w[i] = first_push;
    assign last_pop_w[i] = last_pop;
    assign valid_w[i] = valid_q;
    assign dav_w[i] = dav_q;
    assign ready_w[i] = ready_q;
    assign win_w[i] = win_q;
  end

  // Port fan-out, every bit taken straight from a flop
  assign fill_response_ready = ready_w[`RXB_CH_RSP];
  assign fill_posted_ready = ready_w[`RXB_CH_PST];
  assign fill_nonposted_ready = ready_w[`RXB_CH_NP];

  assign rx_response_data = rd_word_w[`RXB_CH_RSP][`RXB_DAT_MSB:0];
  assign rx_response_empty_code = rxb_mty_t'(rd_word_w[`RXB_CH_RSP][`RXB_MTY_MSB:`RXB_MTY_LSB]);
  assign rx_response_start = rd_word_w[`RXB_CH_RSP][`RXB_SOP_BIT];
  assign rx_response_end = rd_word_w[`RXB_CH_RSP][`RXB_EOP_BIT];
  assign rx_response_word_valid = valid_w[`RXB_CH_RSP];
  assign rx_response_packet_waiting = dav_w[`RXB_CH_RSP];

  assign rx_posted_data = rd_word_w[`RXB_CH_PST][`RXB_DAT_MSB:0];
  assign rx_posted_empty_code = rxb_mty_t'(rd_word_w[`RXB_CH_PST][`RXB_MTY_MSB:`RXB_MTY_LSB]);
  assign rx_posted_start = rd_word_w[`RXB_CH_PST][`RXB_SOP_BIT];
  assign rx_posted_end = rd_word_w[`RXB_CH_PST][`RXB_EOP_BIT];
  assign rx_posted_word_valid = valid_w[`RXB_CH_PST];
  assign rx_posted_packet_waiting = dav_w[`RXB_CH_PST];
  assign rx_posted_window_match_code = win_w[`RXB_CH_PST];

  assign rx_nonposted_data = rd_word_w[`RXB_CH_NP][`RXB_DAT_MSB:0];
  assign rx_nonposted_empty_code = rxb_mty_t'(rd_word_w[`RXB_CH_NP][`RXB_MTY_MSB:`RXB_MTY_LSB]);
  assign rx_nonposted_start = rd_word_w[`RXB_CH_NP][`RXB_SOP_BIT];
  assign rx_nonposted_end = rd_word_w[`RXB_CH_NP][`RXB_EOP_BIT];
  assign rx_nonposted_word_valid = valid_w[`RXB_CH_NP];
  assign rx_nonposted_packet_waiting = dav_w[`RXB_CH_NP];
  assign rx_nonposted_window_match_code = win_w[`RXB_CH_NP];

endmodule : rxb_top

// ---- tb/rxb_top_chk.sv ----
`timescale 1ns/1ps
// Port-level checks on the read side
module rxb_top_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rx_response_pull_enable,
  input wire logic [63:0] rx_response_data,
  input rxb_pkg::rxb_mty_t rx_response_empty_code,
  input wire logic rx_response_start,
  input wire logic rx_response_end,
  input wire logic rx_response_word_valid,
  input wire logic rx_response_packet_waiting,
  input wire logic rx_posted_pull_enable,
  input wire logic rx_posted_start,
  input wire logic rx_posted_word_valid,
  input rxb_pkg::rxb_win_t rx_posted_window_match_code,
  input wire logic rx_nonposted_pull_enable,
  input wire logic rx_nonposted_end,
  input wire logic rx_nonposted_word_valid
);
  import rxb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Framing and hold behaviour of the ports
  a_hold_no_pull: assert property (
    !rx_response_pull_enable |=> $stable(rx_response_word_valid) && $stable(rx_response_data))
    else $error("word moved without pull");
  a_mty_legal: assert property (
    rx_response_word_valid |-> rx_response_empty_code inside {3'h0, 3'h4})
    else $error("bad empty code");
  a_mty_on_end: assert property (
    rx_response_word_valid && rx_response_empty_code != 3'h0 |-> rx_response_end)
    else $error("empty code off end word");
  a_cmd_first: assert property (
    rx_response_pull_enable && (!rx_response_word_valid || rx_response_end) |=>
    !rx_response_word_valid || rx_response_start) else $error("packet without start");
  a_valid_cause: assert property (
    $rose(rx_posted_word_valid) |-> $past(rx_posted_pull_enable)) else $error("valid unasked");
  a_win_used: assert property (
    rx_posted_word_valid && rx_posted_start |-> rx_posted_window_match_code != 3'h6)
    else $error("unused window code");
  a_stream_on: assert property (
    rx_nonposted_word_valid && !rx_nonposted_end && rx_nonposted_pull_enable |=>
    rx_nonposted_word_valid) else $error("gap inside packet");
  // Reset is the antecedent here, so the default disable is lifted
  a_reset_clear: assert property (disable iff (1'b0)
    !rstn |=> !rx_response_word_valid && !rx_response_packet_waiting && !rx_posted_word_valid)
    else $error("reset left port busy");
endmodule : rxb_top_chk

bind rxb_top rxb_top_chk u_chk (.*);

// ---- tb/rxb_rd.sv ----
`timescale 1ns/1ps
// Reader at the far side: mode 1 pulls always, mode 2 stalls half the time
module rxb_rd (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] mode,
  input wire logic valid,
  output logic pull,
  output logic got
);
  logic took_q = 1'b0;
  logic [1:0] cnt_q = 2'h0;
  initial pull = 1'b0;
  // Pull moves just after the edge and holds until the next one
  always @(posedge clk) begin
    cnt_q <= rstn ? cnt_q + 2'h1 : 2'h0;
    pull <= rstn && (mode == 2'h1 || (mode == 2'h2 && cnt_q[1]));
    took_q <= rstn && pull;
  end
  // A word is new only when valid follows a sampled pull; markers ignored otherwise
  assign got = valid && took_q;
endmodule : rxb_rd

// ---- tb/rxb_top_tb.sv ----
`timescale 1ns/1ps
module rxb_top_tb;
  import rxb_pkg::*;
  typedef struct packed {logic [63:0] d; logic s; logic e; logic [2:0] m; logic [2:0] w;} rxb_note_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic lrst_n = 1'b1;
  logic lpg = 1'b1;
  logic fv [3];
  logic [63:0] fd [3];
  logic fe [3];
  logic [2:0] fm [3];
  logic fp [3];
  logic [2:0] fw [3];
  logic fr [3];
  logic pull [3];
  logic [63:0] od [3];
  logic [2:0] om [3];
  logic os [3];
  logic oe [3];
  logic ov [3];
  logic wt [3];
  logic [2:0] oc [3];
  logic got [3];
  logic [1:0] mode [3];
  rxb_note_t exp_q [3][$];
  int fails = 0;
  int total_checks = 0;
  int cyc;
  integer seed = 32'h73cf;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  rxb_top dut (
    .clk(clk), .rstn(rstn), .link_reset_n_in(lrst_n), .link_power_good_in(lpg),
    .fill_response_valid(fv[0]), .fill_response_data(fd[0]), .fill_response_end(fe[0]),
    .fill_response_empty_code(fm[0]), .fill_response_passpw(fp[0]),
    .fill_response_ready(fr[0]),
    .fill_posted_valid(fv[1]), .fill_posted_data(fd[1]), .fill_posted_end(fe[1]),
    .fill_posted_empty_code(fm[1]), .fill_posted_passpw(fp[1]),
    .fill_posted_window(fw[1]), .fill_posted_ready(fr[1]),
    .fill_nonposted_valid(fv[2]), .fill_nonposted_data(fd[2]), .fill_nonposted_end(fe[2]),
    .fill_nonposted_empty_code(fm[2]), .fill_nonposted_passpw(fp[2]),
    .fill_nonposted_window(fw[2]), .fill_nonposted_ready(fr[2]),
    .rx_response_pull_enable(pull[0]), .rx_response_data(od[0]),
    .rx_response_empty_code(om[0]), .rx_response_start(os[0]), .rx_response_end(oe[0]),
    .rx_response_word_valid(ov[0]), .rx_response_packet_waiting(wt[0]),
    .rx_posted_pull_enable(pull[1]), .rx_posted_data(od[1]),
    .rx_posted_empty_code(om[1]), .rx_posted_start(os[1]), .rx_posted_end(oe[1]),
    .rx_posted_word_valid(ov[1]), .rx_posted_packet_waiting(wt[1]),
    .rx_posted_window_match_code(oc[1]),
    .rx_nonposted_pull_enable(pull[2]), .rx_nonposted_data(od[2]),
    .rx_nonposted_empty_code(om[2]), .rx_nonposted_start(os[2]), .rx_nonposted_end(oe[2]),
    .rx_nonposted_word_valid(ov[2]), .rx_nonposted_packet_waiting(wt[2]),
    .rx_nonposted_window_match_code(oc[2])
  );

  // One reader per channel
  for (genvar c = 0; c < 3; c++) begin : g_rd
    rxb_rd u_rd (.clk(clk), .rstn(rstn), .mode(mode[c]), .valid(ov[c]), .pull(pull[c]),
      .got(got[c]));
  end

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Offer one packet word by word; inner empty codes are garbage the block must clean
  task automatic pkt(input int c, input int n, input logic pw, input logic [2:0] w,
      input logic half);
    rxb_note_t e;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      while (fr[c] !== 1'b1) @(negedge clk);
      e = '{{$random(seed), $random(seed)}, i == 0, i == n - 1, 3'h0, w};
      e.m = (e.e && half) ? 3'h4 : 3'h0;
      {fv[c], fd[c], fe[c], fp[c], fw[c]} = {1'b1, e.d, e.e, pw, w};
      fm[c] = e.e ? e.m : 3'($random(seed));
      exp_q[c].push_back(e);
      @(posedge clk);
    end
    @(negedge clk);
    fv[c] = 1'b0;
  endtask : pkt

  // Wait, bounded, until every noted word has come out
  task automatic drain();
    cyc = 0;
    while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() > 0 && cyc < 400) begin
      @(posedge clk);
      cyc++;
    end
    @(negedge clk);
    check(exp_q[0].size() + exp_q[1].size() + exp_q[2].size(), 0);
  endtask : drain

  // Each delivered word is matched against the oldest note of its channel
  always @(negedge clk) begin
    rxb_note_t n;
    for (int c = 0; c < 3; c++) begin
      if (got[c] === 1'b1) begin
        if (exp_q[c].size() == 0) begin
          check(1'b1, 1'b0);
        end else begin
          n = exp_q[c].pop_front();
          check({od[c], os[c], oe[c], om[c]}, {n.d, n.s, n.e, n.m});
          if (c > 0 && n.s) check(oc[c], n.w);
        end
      end
    end
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    foreach (fv[c]) {fv[c], fd[c], fe[c], fm[c], fp[c], fw[c], mode[c]} = '0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    for (int c = 0; c < 3; c++) begin
      check(ov[c], 1'b0);
      check(wt[c], 1'b0);
    end
    check(oc[1], 3'h7);
    $display("test reset done");
    // Stored packets, dataless ones among them, must stream with no gap
    pkt(0, 1, 1'b1, 3'h7, 1'b1);
    pkt(0, 4, 1'b1, 3'h7, 1'b1);
    pkt(0, 3, 1'b1, 3'h7, 1'b0);
    pkt(0, 1, 1'b1, 3'h7, 1'b0);
    repeat (4) @(negedge clk);
    check(wt[0], 1'b1);
    mode[0] = 2'h1;
    drain();
    check(cyc <= 11, 1'b1);
    repeat (3) @(negedge clk);
    check(wt[0], 1'b0);
    $display("test stream done");
    // Every window code except the unused 6 while readers stall
    mode[1] = 2'h2;
    mode[2] = 2'h2;
    for (int w = 0; w < 8; w++) begin
      if (w != 6) begin
        pkt(1, 2, 1'b0, 3'(w), 1'b0);
        pkt(2, 2, 1'b1, 3'(w), 1'b1);
      end
    end
    drain();
    $display("test window done");
    // Without pass permission, packets wait for earlier posted ones
    foreach (mode[c]) mode[c] = 2'h0;
    pkt(1, 2, 1'b0, 3'h3, 1'b0);
    pkt(0, 2, 1'b0, 3'h7, 1'b1);
    pkt(0, 1, 1'b1, 3'h7, 1'b1);
    pkt(2, 1, 1'b0, 3'h7, 1'b1);
    repeat (6) @(negedge clk);
    check(wt[0], 1'b0);
    check(wt[2], 1'b0);
    check(wt[1], 1'b1);
    mode[0] = 2'h1;
    repeat (4) @(negedge clk);
    check(ov[0], 1'b0);
    foreach (mode[c]) mode[c] = 2'h1;
    drain();
    $display("test blocking done");
    // With pass permission, packets overtake unread posted traffic
    foreach (mode[c]) mode[c] = 2'h0;
    pkt(1, 1, 1'b0, 3'h2, 1'b1);
    pkt(1, 2, 1'b1, 3'h4, 1'b0);
    pkt(0, 1, 1'b1, 3'h7, 1'b1);
    pkt(2, 1, 1'b1, 3'h5, 1'b1);
    repeat (6) @(negedge clk);
    check(wt[0], 1'b1);
    check(wt[2], 1'b1);
    mode[0] = 2'h1;
    mode[2] = 2'h1;
    repeat (8) @(negedge clk);
    check(exp_q[0].size() + exp_q[2].size(), 0);
    check(exp_q[1].size(), 3);
    mode[1] = 2'h1;
    drain();
    $display("test passing done");
    // Power loss, then link reset, must drop a stored packet and reopen the fill side
    mode[2] = 2'h0;
    for (int k = 0; k < 2; k++) begin
      pkt(2, 2, 1'b0, 3'h1, 1'b0);
      {lpg, lrst_n} = 2'(1 << k);
      repeat (4) @(negedge clk);
      check({wt[2], fr[2]}, 2'h0);
      {lpg, lrst_n} = 2'h3;
      exp_q[2].delete();
      repeat (4) @(negedge clk);
      check(fr[2], 1'b1);
    end
    // Only the packet written after the flush may come out
    pkt(2, 1, 1'b0, 3'h1, 1'b1);
    mode[2] = 2'h1;
    drain();
    $display("test flush done");
    summarize();
  end
endmodule : rxb_top_tb
